// ==== common/gpps_regs.svh ====
// Register offsets, field masks, reset values and pad indices of the port set
`ifndef GPPS_REGS_SVH
`define GPPS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (address = base + port number)
// ----------------------------------------------------------------
`define GPPS_ADDR_DATA_BASE 8'h00
`define GPPS_ADDR_DIR_BASE 8'h20
`define GPPS_ADDR_PU_BASE 8'h30
`define GPPS_ADDR_PORT_MASK 8'hf8
`define GPPS_PORT_COUNT 3'h7

// ----------------------------------------------------------------
// Port numbers and bit numbers with a special role
// ----------------------------------------------------------------
`define GPPS_PORT_IRQ_LO 3'h0
`define GPPS_PORT_INPUT 3'h1
`define GPPS_PORT_AD_BUS 3'h4
`define GPPS_PORT_IRQ_HI 3'h5
`define GPPS_PORT_STROBE 3'h6
`define GPPS_WAIT_BIT 3'h6
`define GPPS_TOFF_BIT 3'h0
`define GPPS_ADC_EXT_TRIGGER_BIT 3'h3

// ----------------------------------------------------------------
// Implemented two-way bits per port, and the input-only bits of port one
// ----------------------------------------------------------------
`define GPPS_MASK_P0 8'h0f
`define GPPS_MASK_P1 8'h00
`define GPPS_MASK_P2 8'h7f
`define GPPS_MASK_P3 8'hff
`define GPPS_MASK_P4 8'hff
`define GPPS_MASK_P5 8'hff
`define GPPS_MASK_P6 8'hf0
`define GPPS_MASK_IN_P1 8'hff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPPS_RST_DIR 8'hff
`define GPPS_RST_PU 8'h00
`define GPPS_RST_LATCH 8'h00
`define GPPS_RST_BYTE 8'h00

`endif

// ==== common/gpps_pkg.sv ====
// Types shared by the general purpose port set
package gpps_pkg;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef logic [6:0][7:0] gpps_pins_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpps_bus_req_s;

    typedef enum logic [3:0] {
        GPPS_KIND_NONE = 4'b0001,
        GPPS_KIND_DATA = 4'b0010,
        GPPS_KIND_DIR = 4'b0100,
        GPPS_KIND_PU = 4'b1000
    } gpps_kind_e;

    typedef struct packed {
        gpps_kind_e kind;
        logic [2:0] port;
    } gpps_decode_s;

    // ------------------------------------------------------------
    // State of the port set, apart from the pad synchroniser stages
    // ------------------------------------------------------------
    typedef struct packed {
        gpps_pins_t latch;
        gpps_pins_t dir;
        gpps_pins_t pu;
        gpps_pins_t pin_out;
        gpps_pins_t oe_b;
        gpps_pins_t pu_en;
        gpps_pins_t level;
        logic [7:0] rdata;
        logic [7:0] irq_level;
        logic [7:0] irq_edge;
        logic toff;
        logic adc_ext_trigger;
    } gpps_state_s;

endpackage : gpps_pkg

// ==== design/gpps_pin_sync.sv ====
// Two-stage synchroniser for the asynchronous pad inputs
`timescale 1ns/1ps

module gpps_pin_sync #(
    parameter int WIDTH = 56
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } gpps_sync_s;

    gpps_sync_s sync_reg;
    gpps_sync_s sync_next;

    // ------------------------------------------------------------
    // First stage feeds only the second stage
    // ------------------------------------------------------------
    always_comb begin
        sync_next.meta = i_async;
        sync_next.sync = sync_reg.meta;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg.sync;

endmodule : gpps_pin_sync

// ==== design/gpps_port_set.sv ====
// Seven-port pin block: latches, direction, pull-ups and pad muxing
`timescale 1ns/1ps
`include "gpps_regs.svh"

// Function
// RULE1: 47 pins, eight input-only, 39 two-way
// RULE2: Every port accessible per bit or byte
// RULE3: Port zero four bits, direction, pull-up
// RULE4: Port one eight inputs, no latch, pull-up (the code gives port one no pull-up)
// RULE5: Port two seven bits, serial and timer
// RULE6: Port three eight bits, real-time outputs
// RULE7: Port four carries address/data in expansion
// RULE8: Port five eight bits, serial, timer, interrupts
// RULE9: Port six upper nibble, memory strobes
// RULE10: Reset puts two-way pins in input
// RULE11: Port zero feeds interrupts, timer stop, trigger
// RULE12: Port zero output change sets interrupt flag
// RULE13: Port five upper output change sets flag
// RULE14: Software clears latch for alternate outputs
// RULE15: Port six pin six waits if enabled
// RULE16: Software pull-up on every two-way pin
// RULE17: Direction resets to ones, one means input
// RULE18: Pull-ups reset cleared, connect in any mode
// RULE19: Read returns latch or pin, latch unchanged
// RULE20: Input-mode write updates latch only
// RULE21: Writes land on the strobe's clock edge
module gpps_port_set
    import gpps_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire gpps_bus_req_s i_bus,
    output logic [7:0] o_rdata,
    input wire gpps_pins_t i_pin_in,
    output gpps_pins_t o_pin_out,
    output gpps_pins_t o_pin_oe_b,
    output gpps_pins_t o_pullup_en,
    output gpps_pins_t o_pin_level,
    input wire gpps_pins_t i_alt_out,
    input wire logic i_ext_mem_mode,
    input wire logic i_ext_wait_en,
    input wire logic [7:0] i_ad_out,
    input wire logic i_ad_drive,
    input wire logic [7:0] i_mem_strobe,
    output logic [7:0] o_ext_irq_input,
    output logic [7:0] o_ext_irq_edge,
    output logic o_timer_output_stop_in,
    output logic o_adc_ext_trigger
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] impl_mask(input logic [2:0] port);
        logic [7:0] m;
        m = 8'h00;
        case (port)
            3'h0: m = `GPPS_MASK_P0;
            3'h1: m = `GPPS_MASK_P1;
            3'h2: m = `GPPS_MASK_P2;
            3'h3: m = `GPPS_MASK_P3;
            3'h4: m = `GPPS_MASK_P4;
            3'h5: m = `GPPS_MASK_P5;
            3'h6: m = `GPPS_MASK_P6;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : impl_mask

    function automatic gpps_decode_s decode(input logic [7:0] addr);
        gpps_decode_s d;
        logic [7:0] base;
        d.kind = GPPS_KIND_NONE;
        d.port = addr[2:0];
        base = addr & `GPPS_ADDR_PORT_MASK;
        if (d.port < `GPPS_PORT_COUNT) begin
            if (base == `GPPS_ADDR_DATA_BASE) begin
                d.kind = GPPS_KIND_DATA;
            end else if (d.port != `GPPS_PORT_INPUT) begin
                // Port one has no direction and no pull-up [RULE4]
                if (base == `GPPS_ADDR_DIR_BASE) begin
                    d.kind = GPPS_KIND_DIR;
                end else if (base == `GPPS_ADDR_PU_BASE) begin
                    d.kind = GPPS_KIND_PU;
                end
            end
        end
        return d;
    endfunction : decode

    // Bit or byte update of the implemented bits only
    function automatic logic [7:0] merge(
        input logic [7:0] old,
        input gpps_bus_req_s req,
        input logic [7:0] mask
    );
        logic [7:0] val;
        val = req.wdata;
        if (req.bit_op) begin
            val = old;
            val[req.bit_idx] = req.wdata[0]; // [RULE2]
        end
        return (val & mask) | (old & ~mask);
    endfunction : merge

    // ------------------------------------------------------------
    // Pad synchronisation
    // ------------------------------------------------------------
    gpps_pins_t pin_sync;

    gpps_pin_sync #(
        .WIDTH(56)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pin_in),
        .o_sync(pin_sync)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    gpps_state_s st_reg;
    gpps_state_s st_next;
    gpps_decode_s dec;
    gpps_pins_t readback;
    logic [7:0] mask;
    logic [7:0] irq_src;
    logic [7:0] rd_byte;

    always_comb begin
        st_next = st_reg;
        dec = decode(i_bus.addr);
        mask = 8'h00;
        readback = '0;
        rd_byte = 8'h00;

        // Latch in output mode, pin level in input mode
        for (int p = 0; p < 7; p++) begin
            mask = impl_mask(3'(p));
            readback[p] = ((~st_reg.dir[p] & st_reg.latch[p])
                | (st_reg.dir[p] & pin_sync[p])) & mask; // [RULE19]
        end
        readback[`GPPS_PORT_INPUT] = pin_sync[`GPPS_PORT_INPUT]
            & `GPPS_MASK_IN_P1; // [RULE4] [RULE1]

        mask = impl_mask(dec.port);

        // ---------------- Register writes ----------------
        // Latch written whatever the direction [RULE20] [RULE21]
        if (i_bus.wr) begin
            unique case (dec.kind)
                GPPS_KIND_DATA: begin
                    st_next.latch[dec.port] =
                        merge(st_reg.latch[dec.port], i_bus, mask);
                end
                GPPS_KIND_DIR: begin
                    st_next.dir[dec.port] =
                        merge(st_reg.dir[dec.port], i_bus, mask); // [RULE3]
                end
                GPPS_KIND_PU: begin
                    st_next.pu[dec.port] =
                        merge(st_reg.pu[dec.port], i_bus, mask); // [RULE16]
                end
                GPPS_KIND_NONE: begin
                end
            endcase
        end

        // ---------------- Register reads ----------------
        // Unmapped addresses answer zero
        if (i_bus.rd) begin
            unique case (dec.kind)
                GPPS_KIND_DATA: rd_byte = readback[dec.port];
                GPPS_KIND_DIR: rd_byte = st_reg.dir[dec.port];
                GPPS_KIND_PU: rd_byte = st_reg.pu[dec.port];
                GPPS_KIND_NONE: rd_byte = 8'h00;
            endcase
            if (i_bus.bit_op) begin
                rd_byte = {7'h00, rd_byte[i_bus.bit_idx]}; // [RULE2]
            end
            st_next.rdata = rd_byte;
        end

        // ---------------- Pad drive ----------------
        // Alternate outputs OR into the latch, hence latch must be 0
        for (int p = 0; p < 7; p++) begin
            mask = impl_mask(3'(p));
            st_next.pin_out[p] = (st_reg.latch[p] | i_alt_out[p])
                & mask; // [RULE14] [RULE5] [RULE6] [RULE8]
            st_next.oe_b[p] = st_reg.dir[p] | ~mask; // [RULE17]
            // Pull-up follows its bit regardless of mode [RULE18]
            st_next.pu_en[p] = st_reg.pu[p] & mask; // [RULE16]
        end

        if (i_ext_mem_mode) begin
            st_next.pin_out[`GPPS_PORT_AD_BUS] = i_ad_out; // [RULE7]
            st_next.oe_b[`GPPS_PORT_AD_BUS] = {8{~i_ad_drive}};
            st_next.pin_out[`GPPS_PORT_STROBE] = i_mem_strobe
                & `GPPS_MASK_P6; // [RULE9]
            st_next.oe_b[`GPPS_PORT_STROBE] = ~`GPPS_MASK_P6;
            // Wait pin turns into an input when waits are used
            if (i_ext_wait_en) begin
                st_next.oe_b[`GPPS_PORT_STROBE][`GPPS_WAIT_BIT] =
                    1'b1; // [RULE15]
                st_next.pin_out[`GPPS_PORT_STROBE][`GPPS_WAIT_BIT] =
                    1'b0;
            end
        end

        st_next.level = readback;

        // ---------------- Interrupt sources ----------------
        // Readback shows the latch in output mode, so a latch change
        // looks like a pin edge; software masks first
        irq_src = {readback[`GPPS_PORT_IRQ_HI][7:4],
            readback[`GPPS_PORT_IRQ_LO][3:0]}; // [RULE11]
        st_next.irq_level = irq_src;
        st_next.irq_edge = irq_src ^ st_reg.irq_level; // [RULE12] [RULE13]
        st_next.toff = readback[`GPPS_PORT_IRQ_LO][`GPPS_TOFF_BIT];
        st_next.adc_ext_trigger = readback[`GPPS_PORT_IRQ_LO][`GPPS_ADC_EXT_TRIGGER_BIT];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
            st_reg.latch <= {7{`GPPS_RST_LATCH}};
            st_reg.dir <= {7{`GPPS_RST_DIR}}; // [RULE17] [RULE10]
            st_reg.pu <= {7{`GPPS_RST_PU}}; // [RULE18]
            st_reg.oe_b <= {7{`GPPS_RST_DIR}}; // [RULE10]
            st_reg.rdata <= `GPPS_RST_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = st_reg.rdata;
    assign o_pin_out = st_reg.pin_out;
    assign o_pin_oe_b = st_reg.oe_b;
    assign o_pullup_en = st_reg.pu_en;
    assign o_pin_level = st_reg.level;
    assign o_ext_irq_input = st_reg.irq_level;
    assign o_ext_irq_edge = st_reg.irq_edge;
    assign o_timer_output_stop_in = st_reg.toff;
    assign o_adc_ext_trigger = st_reg.adc_ext_trigger;

endmodule : gpps_port_set

// ==== tb/gpps_port_set_chk.sv ====
// Assertions on the outer ports of the port set
`timescale 1ns/1ps
module gpps_port_set_chk
    import gpps_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire gpps_bus_req_s i_bus,
    input wire logic [7:0] o_rdata,
    input wire gpps_pins_t o_pin_oe_b,
    input wire gpps_pins_t o_pullup_en,
    input wire logic [7:0] o_ext_irq_input,
    input wire logic [7:0] o_ext_irq_edge
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // ------------------------------------------------------------
    // Bus steps
    // ------------------------------------------------------------
    sequence dir3_wr;
        i_bus.wr && !i_bus.bit_op && i_bus.addr == 8'h23;
    endsequence
    sequence pu5_wr;
        i_bus.wr && !i_bus.bit_op && i_bus.addr == 8'h35;
    endsequence
    sequence odd_rd;
        i_bus.rd && (i_bus.addr[2:0] == 3'h7 || i_bus.addr == 8'h21 ||
            i_bus.addr == 8'h31 ||
            !(i_bus.addr[7:3] inside {5'h00, 5'h04, 5'h06}));
    endsequence
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    port1_hiz_a: assert property (o_pin_oe_b[1] == 8'hff)
        else $error("input-only port driven");
    unimpl_hiz_a: assert property (o_pin_oe_b[0][7:4] == 4'hf &&
        o_pin_oe_b[2][7] && o_pin_oe_b[6][3:0] == 4'hf)
        else $error("missing pin driven");
    pullup_none_a: assert property (o_pullup_en[1] == 8'h00 &&
        o_pullup_en[0][7:4] == 4'h0 && !o_pullup_en[2][7] &&
        o_pullup_en[6][3:0] == 4'h0)
        else $error("pull-up on a pin without one");
    unmapped_rd_a: assert property (odd_rd |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    dir_wr_a: assert property (dir3_wr |-> ##2
        o_pin_oe_b[3] == $past(i_bus.wdata, 2))
        else $error("direction write not on enables");
    pu_wr_a: assert property (pu5_wr |-> ##2
        o_pullup_en[5] == $past(i_bus.wdata, 2))
        else $error("pull-up write not on pads");
    dir_hold_a: assert property ($changed(o_pin_oe_b[3]) |->
        $past(i_bus.wr, 2) && $past(i_bus.addr, 2) == 8'h23)
        else $error("enables moved without a write");
    irq_edge_a: assert property (o_ext_irq_edge ==
        (o_ext_irq_input ^ $past(o_ext_irq_input)))
        else $error("request pulse not tied to level change");
endmodule : gpps_port_set_chk

// ==== tb/gpps_pad_model.sv ====
// Pad ring model: pin drivers, pull-ups and outside sources
`timescale 1ns/1ps
module gpps_pad_model
    import gpps_pkg::*;
(
    input wire logic i_sys_clk,
    input wire gpps_pins_t i_drive,
    input wire gpps_pins_t i_oe_b,
    input wire gpps_pins_t i_pullup,
    input wire gpps_pins_t i_ext_val,
    input wire gpps_pins_t i_ext_en,
    output gpps_pins_t o_level
);
    // ------------------------------------------------------------
    // Wire level
    // ------------------------------------------------------------
    gpps_pins_t last_reg = '0;
    // Floating pins flip each cycle so a stale level never passes
    always @(posedge i_sys_clk) last_reg <= o_level;
    assign o_level = (~i_oe_b & i_drive)
        | (i_oe_b & i_ext_en & i_ext_val)
        | (i_oe_b & ~i_ext_en & i_pullup)
        | (i_oe_b & ~i_ext_en & ~i_pullup & ~last_reg);
endmodule : gpps_pad_model

// ==== tb/gpps_port_set_bench.sv ====
// Self-checking bench for the port set
`timescale 1ns/1ps
`include "gpps_regs.svh"
module gpps_port_set_bench
    import gpps_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam gpps_pins_t MASKS = {`GPPS_MASK_P6, `GPPS_MASK_P5,
        `GPPS_MASK_P4, `GPPS_MASK_P3, `GPPS_MASK_P2, `GPPS_MASK_P1,
        `GPPS_MASK_P0};
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    gpps_bus_req_s bus = '0;
    gpps_pins_t alt = '0, ext_val = '0, ext_en = '1;
    logic mem_mode = 1'b0, wait_en = 1'b0, ad_drive = 1'b0;
    logic [7:0] ad_out = 8'h00, strobe = 8'h00;
    gpps_pins_t pins, pin_out, oe_b, pu_en, lvl;
    logic [7:0] rdata, irq_in, irq_edge, e;
    logic toff, trig;
    int n_errors = 0, n_tests = 0;
    gpps_port_set i_dut (.i_sys_clk, .i_rst_b, .i_bus(bus), .o_rdata(rdata),
        .i_pin_in(pins), .o_pin_out(pin_out), .o_pin_oe_b(oe_b),
        .o_pullup_en(pu_en), .o_pin_level(lvl), .i_alt_out(alt),
        .i_ext_mem_mode(mem_mode), .i_ext_wait_en(wait_en),
        .i_ad_out(ad_out), .i_ad_drive(ad_drive), .i_mem_strobe(strobe),
        .o_ext_irq_input(irq_in), .o_ext_irq_edge(irq_edge),
        .o_timer_output_stop_in(toff), .o_adc_ext_trigger(trig));
    gpps_pad_model i_pads (.i_sys_clk, .i_drive(pin_out), .i_oe_b(oe_b),
        .i_pullup(pu_en), .i_ext_val(ext_val), .i_ext_en(ext_en),
        .o_level(pins));
    always #5 i_sys_clk = ~i_sys_clk;
    // Request pulses are one cycle wide, so gather them for a check
    always @(posedge i_sys_clk) e <= e | irq_edge;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic b = 1'b0, input logic [2:0] idx = 3'h0);
        @(posedge i_sys_clk);
        bus <= {1'b1, 1'b0, b, idx, a, d};
        @(posedge i_sys_clk);
        bus.wr <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
            input logic b = 1'b0, input logic [2:0] idx = 3'h0);
        @(posedge i_sys_clk);
        bus <= {1'b0, 1'b1, b, idx, a, 8'h00};
        @(posedge i_sys_clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd
    task automatic end_sim();
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(oe_b, {7{8'hff}});
        chk(pu_en, {7{8'h00}});
        for (int p = 0; p < 7; p++) begin
            rd(8'h20 + 8'(p), p == 1 ? 8'h00 : 8'hff);
            rd(8'h30 + 8'(p), 8'h00);
        end
    endtask : t_reset
    task automatic t_mask();
        for (int p = 0; p < 7; p++) begin
            wr(8'h30 + 8'(p), 8'hff);
            wr(8'h20 + 8'(p), 8'h00);
            rd(8'h30 + 8'(p), MASKS[p]);
            rd(8'h20 + 8'(p), p == 1 ? 8'h00 : ~MASKS[p]);
        end
        chk(pu_en, MASKS);
        chk(oe_b ^ MASKS, {7{8'hff}});
        for (int p = 0; p < 7; p++) begin
            wr(8'h20 + 8'(p), 8'hff);
            wr(8'h30 + 8'(p), 8'h00);
        end
    endtask : t_mask
    task automatic t_port3();
        @(posedge i_sys_clk);
        ext_val[3] <= 8'h33;
        wr(8'h03, 8'h5a);
        chk(oe_b[3], 8'hff);
        rd(8'h03, 8'h33);
        wr(8'h23, 8'h00);
        chk(pins[3], 8'h5a);
        chk(lvl[3], 8'h5a);
        rd(8'h03, 8'h5a);
        wr(8'h03, 8'h01, 1'b1, 3'h0);
        rd(8'h03, 8'h5b);
        rd(8'h03, 8'h01, 1'b1, 3'h3);
        rd(8'h03, 8'h00, 1'b1, 3'h2);
        wr(8'h23, 8'hff);
    endtask : t_port3
    task automatic t_port1();
        @(posedge i_sys_clk);
        ext_val[1] <= 8'ha5;
        wr(8'h01, 8'h3c);
        rd(8'h01, 8'ha5);
        rd(8'h21, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h40, 8'h00);
        chk(oe_b[1], 8'hff);
    endtask : t_port1
    task automatic t_irq();
        wr(8'h25, 8'h00);
        wr(8'h20, 8'h00);
        e = 8'h00;
        wr(8'h00, 8'h09);
        chk(e, 8'h09);
        chk({toff, trig}, 2'b11);
        e = 8'h00;
        wr(8'h05, 8'h10);
        chk(e, 8'h10);
        chk(irq_in, 8'h19);
        wr(8'h20, 8'hff);
        wr(8'h25, 8'hff);
    endtask : t_irq
    task automatic t_alt();
        wr(8'h22, 8'hfd); // Latch stays 0 under the alternate output
        @(posedge i_sys_clk);
        alt[2] <= 8'h02;
        mem_mode <= 1'b1;
        ad_drive <= 1'b1;
        ad_out <= 8'h3c;
        strobe <= 8'hb0;
        repeat (3) @(posedge i_sys_clk);
        #1 chk({oe_b[2], pin_out[2]}, 16'hfd02);
        chk({oe_b[4], pin_out[4]}, 16'h003c);
        chk({oe_b[6], pin_out[6][7:4]}, 12'h0fb);
        @(posedge i_sys_clk);
        wait_en <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1 chk(oe_b[6], 8'h4f);
    endtask : t_alt
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        t_reset();
        t_mask();
        t_port3();
        t_port1();
        t_irq();
        t_alt();
        end_sim();
    end
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end
endmodule : gpps_port_set_bench

bind gpps_port_set gpps_port_set_chk i_chk (.i_sys_clk, .i_rst_b, .i_bus,
    .o_rdata, .o_pin_oe_b, .o_pullup_en, .o_ext_irq_input, .o_ext_irq_edge);
